// *** hw/microprogram_sequencer.v ***
// microprogram_sequencer.v: location counter, microcommand register,
// return stack, loop counter and control-store fetch path
// assumes a control store with combinational read and no clock of read latency
`timescale 1ns/1ps
`default_nettype none
`include "sequencer_defs.vh"

module microprogram_sequencer #(
    parameter [`ADDR_W:0] STORE_WORDS = 13'h1000
) (
    // clock and reset
    input  wire                      clock,
    input  wire                      rstn,
    // reset causes, status clear and status flags
    input  wire                      system_error,
    input  wire                      power_up,
    input  wire                      status_clear,
    output reg                       error_flag_reg,
    output reg                       power_flag_reg,
    // control store
    output wire [`ADDR_W-1:0]        store_addr,
    input  wire [`WORD_W-1:0]        store_word,
    // writable control store on the system bus
    input  wire                      wcs_select,
    input  wire [`WORD_W-1:0]        wcs_word,
    input  wire                      wcs_access,
    input  wire                      wcs_write,
    input  wire [`ADDR_W-1:0]        wcs_addr,
    input  wire [`WORD_W-1:0]        wcs_wdata,
    output reg  [`WORD_W-1:0]        wcs_rdata_reg,
    output reg                       wcs_rvalid_reg,
    output wire                      wcs_we,
    output wire [`ADDR_W-1:0]        wcs_waddr,
    output wire [`WORD_W-1:0]        wcs_wword,
    // modifier
    input  wire                      modify_enable,
    input  wire [`WORD_W-1:0]        modify_mask,
    input  wire [`WORD_W-1:0]        modify_value,
    // console
    input  wire                      console_load,
    input  wire [`WORD_W-1:0]        console_word,
    input  wire                      hold,
    // patch blocks
    input  wire [1:0]                patch_enable,
    input  wire [`PATCH_BLK_W-1:0]   patch_block0,
    input  wire [`PATCH_BLK_W-1:0]   patch_block1,
    input  wire                      patch_write,
    input  wire                      patch_sel,
    input  wire [`PATCH_AW-1:0]      patch_waddr,
    input  wire [`WORD_W-1:0]        patch_wdata,
    // sequence control from decode
    input  wire [2:0]                next_source,
    input  wire                      branch_cond,
    input  wire [`ADDR_W-1:0]        result_bus,
    input  wire [`SHORT_W-1:0]       emul_vector,
    input  wire [`VEC_W-1:0]         intr_vector,
    input  wire                      page_select,
    input  wire                      page_toggle,
    input  wire [1:0]                stack_op,
    input  wire                      stack_up,
    input  wire                      stack_down,
    input  wire [1:0]                loop_op,
    input  wire [`LOOP_W-1:0]        loop_value,
    input  wire                      repeat_step,
    input  wire                      read_location,
    // outputs
    output reg  [`WORD_W-1:0]        microcommand_register_reg,
    output reg  [`ADDR_W-1:0]        location_counter_reg,
    output reg  [`AOP_W-1:0]         a_operand_bus,
    output reg                       a_operand_valid,
    output wire [`ADDR_W-1:0]        stack_top,
    output reg  [`LOOP_W-1:0]        loop_counter_reg,
    output reg                       loop_taken
);

    reg  [`ADDR_W-1:0]       stack_mem [0:`STACK_DEPTH-1];
    reg  [`STACK_PTR_W-1:0]  stack_ptr_reg;
    reg  [`STACK_PTR_W-1:0]  stack_ptr_next;
    reg  [`ADDR_W-1:0]       location_next;
    reg  [`LOOP_W-1:0]       loop_next;
    reg                      change;
    reg                      repeat_hold;
    wire [`WORD_W-1:0]       patched_word;
    wire [`WORD_W-1:0]       raw_word;
    wire [`WORD_W-1:0]       fetch_word;
    wire [`ADDR_W-1:0]       loc_plus_one;
    wire                     loop_zero;
    integer                  i;

    // short-branch address inside the current 2K area
    function [`ADDR_W-1:0] short_branch;
        input [`ADDR_W-1:0] current;
        input [`SHORT_W-1:0] target;
        begin
            short_branch = {current[`ADDR_W-1], target};
        end
    endfunction

    // fold an address into the fitted store size
    function [`ADDR_W-1:0] fit_size;
        input [`ADDR_W-1:0] addr;
        reg   [`ADDR_W:0]   wide;
        begin
            wide = STORE_WORDS - 13'h0001;
            fit_size = addr & wide[`ADDR_W-1:0];
        end
    endfunction

    assign store_addr = fit_size(location_counter_reg);
    assign loc_plus_one = location_counter_reg + 12'h001;
    assign stack_top = stack_mem[stack_ptr_reg];
    assign loop_zero = (loop_counter_reg == `LOOP_RESET);

    assign wcs_we    = wcs_access && wcs_write;
    assign wcs_waddr = wcs_addr;
    assign wcs_wword = wcs_wdata;
    assign raw_word = wcs_select ? wcs_word : store_word;

    patch_store patch_unit (
        .clock        (clock),
        .rstn         (rstn),
        .patch_enable (patch_enable),
        .patch_block0 (patch_block0),
        .patch_block1 (patch_block1),
        .patch_write  (patch_write),
        .patch_sel    (patch_sel),
        .patch_waddr  (patch_waddr),
        .patch_wdata  (patch_wdata),
        .fetch_addr   (store_addr),
        .store_word   (raw_word),
        .fetched_word (patched_word)
    );

    assign fetch_word = modify_enable ?
        ((patched_word & ~modify_mask) | (modify_value & modify_mask)) : patched_word;

    // loop counter and tested branch
    always @* begin
        loop_next = loop_counter_reg;
        loop_taken = 1'b0;
        repeat_hold = 1'b0;
        case (loop_op)
            `LOOP_LOAD: begin
                loop_next = loop_value;
            end
            `LOOP_TEST_Z: begin
                loop_next = loop_counter_reg - 8'h01;
                loop_taken = loop_zero;
            end
            `LOOP_TEST_NZ: begin
                loop_next = loop_counter_reg - 8'h01;
                loop_taken = !loop_zero;
            end
            default: begin
                loop_next = loop_counter_reg;
            end
        endcase
        if (repeat_step && loop_op == `LOOP_NONE && !loop_zero) begin
            loop_next = loop_counter_reg - 8'h01;
            repeat_hold = 1'b1;
        end
    end

    // next location select
    always @* begin
        change = 1'b0;
        location_next = loc_plus_one;
        case (next_source)
            `SRC_BRANCH: begin
                change = branch_cond || loop_taken;
                if (page_toggle) begin
                    location_next = {page_select, microcommand_register_reg[`SHORT_W-1:0]};
                end else begin
                    location_next = short_branch(location_counter_reg,
                                                 microcommand_register_reg[`SHORT_W-1:0]);
                end
            end
            `SRC_RESULT: begin
                change = branch_cond;
                location_next = result_bus;
            end
            `SRC_STACK: begin
                change = 1'b1;
                location_next = stack_top;
            end
            `SRC_EMUL: begin
                change = 1'b1;
                location_next = short_branch(location_counter_reg, emul_vector);
            end
            `SRC_INTR: begin
                change = 1'b1;
                location_next = {4'h0, intr_vector};
            end
            default: begin
                change = 1'b0;
            end
        endcase
        if (!change) begin
            location_next = repeat_hold ? location_counter_reg : loc_plus_one;
        end
    end

    // stack pointer
    always @* begin
        stack_ptr_next = stack_ptr_reg;
        if (stack_up && !stack_down) begin
            stack_ptr_next = stack_ptr_reg + 4'h1;
        end else if (stack_down && !stack_up) begin
            stack_ptr_next = stack_ptr_reg - 4'h1;
        end
    end

    // counter, flags, pointer, loop
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            location_counter_reg <= `LOC_RESET;
            error_flag_reg <= 1'b0;
            power_flag_reg <= 1'b1;
            stack_ptr_reg <= `SP_RESET;
            loop_counter_reg <= `LOOP_RESET;
        end else begin
            if (status_clear) begin
                error_flag_reg <= 1'b0;
                power_flag_reg <= 1'b0;
            end
            if (system_error) begin
                error_flag_reg <= 1'b1;
            end
            if (power_up) begin
                power_flag_reg <= 1'b1;
            end
            if (system_error || power_up) begin
                location_counter_reg <= `LOC_RESET;
            end else if (!hold) begin
                location_counter_reg <= location_next;
            end
            if (!hold) begin
                stack_ptr_reg <= stack_ptr_next;
                loop_counter_reg <= loop_next;
            end
        end
    end

    always @(posedge clock) begin
        if (!hold && (stack_op == `STK_SAVE || stack_op == `STK_RET_SAVE)) begin
            stack_mem[stack_ptr_reg] <= location_counter_reg;
        end
    end

    // microcommand register and readouts
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            microcommand_register_reg <= {`WORD_W{1'b0}};
            a_operand_bus <= {`AOP_W{1'b0}};
            a_operand_valid <= 1'b0;
            wcs_rdata_reg <= {`WORD_W{1'b0}};
            wcs_rvalid_reg <= 1'b0;
        end else begin
            if (console_load) begin
                microcommand_register_reg <= console_word;
            end else if (!hold) begin
                microcommand_register_reg <= fetch_word;
            end
            a_operand_valid <= read_location;
            if (read_location) begin
                a_operand_bus <= {4'h0, location_counter_reg};
            end
            wcs_rvalid_reg <= wcs_access && !wcs_write;
            if (wcs_access && !wcs_write) begin
                wcs_rdata_reg <= wcs_word;
            end
        end
    end

    initial begin
        for (i = 0; i < `STACK_DEPTH; i = i + 1) begin
            stack_mem[i] = {`ADDR_W{1'b0}};
        end
    end

endmodule // microprogram_sequencer

`default_nettype wire

// *** hw/patch_store.v ***
// patch_store.v: two 32-word auxiliary blocks substituting control-store words
// assumes console writes blocks synchronously with the processor clock
`timescale 1ns/1ps
`default_nettype none
`include "sequencer_defs.vh"

module patch_store (
    // clock and reset
    input  wire                      clock,
    input  wire                      rstn,
    // block enables and designated block numbers
    input  wire [1:0]                patch_enable,
    input  wire [`PATCH_BLK_W-1:0]   patch_block0,
    input  wire [`PATCH_BLK_W-1:0]   patch_block1,
    // console write port
    input  wire                      patch_write,
    input  wire                      patch_sel,
    input  wire [`PATCH_AW-1:0]      patch_waddr,
    input  wire [`WORD_W-1:0]        patch_wdata,
    // fetch side
    input  wire [`ADDR_W-1:0]        fetch_addr,
    input  wire [`WORD_W-1:0]        store_word,
    output reg  [`WORD_W-1:0]        fetched_word
);

    reg  [`WORD_W-1:0] block0_mem [0:`PATCH_WORDS-1];
    reg  [`WORD_W-1:0] block1_mem [0:`PATCH_WORDS-1];
    wire [`PATCH_BLK_W-1:0] fetch_blk;
    wire [`PATCH_AW-1:0]    fetch_off;
    wire                    hit0;
    wire                    hit1;

    assign fetch_blk = fetch_addr[`ADDR_W-1:`PATCH_AW];
    assign fetch_off = fetch_addr[`PATCH_AW-1:0];
    assign hit0 = patch_enable[0] && (fetch_blk == patch_block0);
    assign hit1 = patch_enable[1] && (fetch_blk == patch_block1);

    always @(posedge clock) begin
        if (patch_write && !patch_sel) begin
            block0_mem[patch_waddr] <= patch_wdata;
        end
        if (patch_write && patch_sel) begin
            block1_mem[patch_waddr] <= patch_wdata;
        end
    end

    always @* begin
        if (hit0) begin
            fetched_word = block0_mem[fetch_off];
        end else if (hit1) begin
            fetched_word = block1_mem[fetch_off];
        end else begin
            fetched_word = store_word;
        end
    end

endmodule // patch_store

`default_nettype wire

// *** hw/sequencer_defs.vh ***
// sequencer_defs.vh: constants for the microprogram sequencer
// assumes inclusion by bare name from hw/ design files
`ifndef SEQUENCER_DEFS_VH
`define SEQUENCER_DEFS_VH

// widths
`define WORD_W        48
`define ADDR_W        12
`define SHORT_W       11
`define VEC_W         8
`define LOOP_W        8
`define STACK_DEPTH   16
`define STACK_PTR_W   4
`define PATCH_WORDS   32
`define PATCH_AW      5
`define PATCH_BLK_W   7
`define AOP_W         16

// reset values
`define LOC_RESET     12'h000
`define LOOP_RESET    8'h00
`define SP_RESET      4'h0

// location sources
`define SRC_NONE      3'h0
`define SRC_BRANCH    3'h1
`define SRC_RESULT    3'h2
`define SRC_STACK     3'h3
`define SRC_EMUL      3'h4
`define SRC_INTR      3'h5

// stack ops
`define STK_NONE      2'h0
`define STK_SAVE      2'h1
`define STK_RETURN    2'h2
`define STK_RET_SAVE  2'h3

// loop ops
`define LOOP_NONE     2'h0
`define LOOP_LOAD     2'h1
`define LOOP_TEST_Z   2'h2
`define LOOP_TEST_NZ  2'h3

`endif

// *** tb/microprogram_sequencer_properties.sv ***
// microprogram_sequencer_properties.sv: port checks on the sequencer
// assumes binding onto each sequencer instance
`timescale 1ns/1ps
`default_nettype none
module microprogram_sequencer_properties #(
    parameter [12:0] STORE_WORDS = 13'h1000
) (
    // clock, reset, causes
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        system_error,
    input wire logic        power_up,
    input wire logic        error_flag_reg,
    // fetch
    input wire logic [11:0] store_addr,
    input wire logic [47:0] store_word,
    input wire logic        wcs_select,
    input wire logic        modify_enable,
    input wire logic        console_load,
    input wire logic [47:0] console_word,
    input wire logic        hold,
    input wire logic [1:0]  patch_enable,
    // control and state
    input wire logic [2:0]  next_source,
    input wire logic        branch_cond,
    input wire logic [11:0] result_bus,
    input wire logic [7:0]  intr_vector,
    input wire logic        page_toggle,
    input wire logic [1:0]  stack_op,
    input wire logic        stack_up,
    input wire logic        stack_down,
    input wire logic [1:0]  loop_op,
    input wire logic        repeat_step,
    input wire logic        read_location,
    input wire logic [47:0] microcommand_register_reg,
    input wire logic [11:0] location_counter_reg,
    input wire logic [15:0] a_operand_bus,
    input wire logic        a_operand_valid,
    input wire logic [11:0] stack_top,
    input wire logic [7:0]  loop_counter_reg
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rstn);
    logic go;
    assign go = !hold && !system_error && !power_up;
    addr_map_a: assert property (
        store_addr == (location_counter_reg & (STORE_WORDS[11:0] - 12'h001)))
        else $error("store address");
    count_up_a: assert property (
        go && next_source == 3'h0 && !repeat_step |=>
        location_counter_reg == $past(location_counter_reg) + 12'h001)
        else $error("no advance");
    result_load_a: assert property (
        go && next_source == 3'h2 && branch_cond |=> location_counter_reg == $past(result_bus))
        else $error("result branch");
    short_branch_a: assert property (
        go && next_source == 3'h1 && branch_cond && !page_toggle |=>
        location_counter_reg == {$past(location_counter_reg[11]),
        $past(microcommand_register_reg[10:0])})
        else $error("short branch");
    intr_load_a: assert property (
        go && next_source == 3'h5 |=> location_counter_reg == {4'h0, $past(intr_vector)})
        else $error("interrupt entry");
    stack_return_a: assert property (
        go && next_source == 3'h3 |=> location_counter_reg == $past(stack_top))
        else $error("return");
    stack_save_a: assert property (
        !hold && stack_op == 2'h1 && !stack_up && !stack_down |=>
        stack_top == $past(location_counter_reg))
        else $error("save");
    fault_reset_a: assert property (
        !hold && system_error |=> location_counter_reg == 12'h000 && error_flag_reg)
        else $error("fault reset");
    fetch_pipe_a: assert property (
        go && !console_load && !wcs_select && !modify_enable && patch_enable == 2'b00
        |=> microcommand_register_reg == $past(store_word))
        else $error("fetch");
    console_load_a: assert property (
        console_load |=> microcommand_register_reg == $past(console_word))
        else $error("console");
    read_loc_a: assert property (
        read_location && !hold |=>
        a_operand_valid && a_operand_bus == {4'h0, $past(location_counter_reg)})
        else $error("read location");
    loop_dec_a: assert property (
        !hold && loop_op[1] && loop_counter_reg != 8'h00 |=>
        loop_counter_reg == $past(loop_counter_reg) - 8'h01)
        else $error("loop test");
endmodule // microprogram_sequencer_properties
bind microprogram_sequencer microprogram_sequencer_properties #(.STORE_WORDS(STORE_WORDS)) chk (
    .clock, .rstn, .system_error, .power_up, .error_flag_reg, .store_addr, .store_word,
    .wcs_select, .modify_enable, .console_load, .console_word, .hold, .patch_enable,
    .next_source, .branch_cond, .result_bus, .intr_vector, .page_toggle, .stack_op,
    .stack_up, .stack_down, .loop_op, .repeat_step, .read_location,
    .microcommand_register_reg, .location_counter_reg, .a_operand_bus, .a_operand_valid,
    .stack_top, .loop_counter_reg);
`default_nettype wire

// *** tb/store_model.sv ***
// store_model.sv: control store and writable store facing the sequencer
// assumes the bench knows the fixed word pattern
`timescale 1ns/1ps
`default_nettype none
module store_model (
    // clock
    input  wire logic        clock,
    // fetch side
    input  wire logic [11:0] store_addr,
    output logic      [47:0] store_word,
    output logic      [47:0] wcs_word,
    // writable store load
    input  wire logic        wcs_we,
    input  wire logic [11:0] wcs_waddr,
    input  wire logic [47:0] wcs_wword
);
    logic [47:0] ram [0:4095];
    assign store_word = {store_addr, ~store_addr, store_addr, ~store_addr};
    assign wcs_word = ram[store_addr];
    always @(posedge clock) begin
        if (wcs_we) begin
            ram[wcs_waddr] <= wcs_wword;
        end
    end
endmodule // store_model
`default_nettype wire

// *** tb/test_microprogram_sequencer.sv ***
// test_microprogram_sequencer.sv: directed bench for the sequencer
// assumes store_model supplies the fetched words
`timescale 1ns/1ps
`default_nettype none
module test_microprogram_sequencer;
    logic clock, rstn, system_error, power_up, status_clear, wcs_select, wcs_access;
    logic wcs_write, modify_enable, console_load, hold, patch_write, branch_cond;
    logic page_select, page_toggle, stack_up, stack_down, repeat_step, read_location;
    logic error_flag_reg, power_flag_reg, a_operand_valid, wcs_we, loop_taken, wcs_rvalid_reg;
    logic [1:0] patch_enable, stack_op, loop_op;
    logic [2:0] next_source;
    logic [4:0] patch_waddr;
    logic [6:0] patch_block0;
    logic [7:0] intr_vector, loop_value, loop_counter_reg;
    logic [10:0] emul_vector;
    logic [11:0] wcs_addr, result_bus, store_addr, stack_top, wcs_waddr, location_counter_reg;
    logic [15:0] a_operand_bus;
    logic [47:0] modify_mask, modify_value, console_word, patch_wdata, wcs_wdata;
    logic [47:0] store_word, wcs_word, wcs_wword, microcommand_register_reg, wcs_rdata_reg;
    int errors, n_tests;
    microprogram_sequencer dut (.clock, .rstn, .system_error, .power_up, .status_clear,
        .error_flag_reg, .power_flag_reg, .store_addr, .store_word, .wcs_select, .wcs_word,
        .wcs_access, .wcs_write, .wcs_addr, .wcs_wdata, .wcs_rdata_reg, .wcs_rvalid_reg,
        .wcs_we, .wcs_waddr, .wcs_wword, .modify_enable, .modify_mask, .modify_value,
        .console_load, .console_word, .hold, .patch_enable, .patch_block0,
        .patch_block1(7'h00), .patch_write, .patch_sel(1'b0), .patch_waddr, .patch_wdata,
        .next_source, .branch_cond, .result_bus, .emul_vector, .intr_vector, .page_select,
        .page_toggle, .stack_op, .stack_up, .stack_down, .loop_op, .loop_value, .repeat_step,
        .read_location, .microcommand_register_reg, .location_counter_reg, .a_operand_bus,
        .a_operand_valid, .stack_top, .loop_counter_reg, .loop_taken);
    store_model mem (.clock, .store_addr, .store_word, .wcs_word, .wcs_we, .wcs_waddr,
        .wcs_wword);
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task chk(input logic [47:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task end_sim;
        if (errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // one sequence change, counter compared after it
    task seq(input logic [2:0] src, input logic [11:0] val, exp);
        @(posedge clock);
        {next_source, branch_cond, result_bus} <= {src, 1'b1, val};
        {emul_vector, intr_vector} <= {val[10:0], val[7:0]};
        @(posedge clock);
        {next_source, branch_cond} <= 4'h0;
        #1 chk(location_counter_reg, exp);
    endtask
    task save(input logic [11:0] exp);
        @(posedge clock);
        stack_op <= 2'h1;
        @(posedge clock);
        stack_op <= 2'h0;
        #1 chk(stack_top, exp);
    endtask
    task hit(input logic e, p, input logic [1:0] fl);
        @(posedge clock);
        {system_error, power_up, next_source, branch_cond} <= {e, p, 3'h2, 1'b1};
        @(posedge clock);
        {system_error, power_up, next_source, branch_cond} <= '0;
        #1 chk({location_counter_reg, error_flag_reg, power_flag_reg}, {12'h000, fl});
    endtask
    task t_count;
        #1 chk({location_counter_reg, power_flag_reg}, 13'h0001);
        seq(3'h2, 12'hFFE, 12'hFFE);
        @(posedge clock);
        #1 chk(microcommand_register_reg, 48'hFFE001FFE001);
        @(posedge clock);
        #1 chk(location_counter_reg, 12'h000);
    endtask
    task t_branch;
        for (int i = 0; i < 2; i++) begin
            seq(3'h2, i ? 12'h010 : 12'h800, i ? 12'h010 : 12'h800);
            seq(3'h1, 12'h000, i ? 12'h7EF : 12'hFFF);
        end
        seq(3'h2, 12'h9AB, 12'h9AB);
        seq(3'h4, 12'h123, 12'h923);
        seq(3'h5, 12'hFC5, 12'h0C5);
    endtask
    task t_stack;
        seq(3'h2, 12'h345, 12'h345);
        save(12'h346);
        @(posedge clock);
        stack_up <= 1'b1;
        @(posedge clock);
        stack_up <= 1'b0;
        seq(3'h2, 12'h5A0, 12'h5A0);
        save(12'h5A1);
        seq(3'h3, 12'h000, 12'h5A1);
        @(posedge clock);
        stack_down <= 1'b1;
        @(posedge clock);
        stack_down <= 1'b0;
        seq(3'h3, 12'h000, 12'h346);
    endtask
    task t_loop;
        @(posedge clock);
        {loop_op, loop_value} <= {2'h1, 8'h05};
        @(posedge clock);
        loop_op <= 2'h3;
        #1 chk(loop_counter_reg, 8'h05);
        chk(loop_taken, 1'b1);
        @(posedge clock);
        loop_op <= 2'h2;
        @(posedge clock);
        loop_op <= 2'h0;
        #1 chk(loop_counter_reg, 8'h03);
        seq(3'h2, 12'h100, 12'h100);
        @(posedge clock);
        repeat_step <= 1'b1;
        @(posedge clock);
        repeat_step <= 1'b0;
        #1 chk({location_counter_reg, loop_counter_reg}, 20'h10102);
    endtask
    task t_misc;
        hit(1'b1, 1'b0, 2'b11);
        @(posedge clock);
        status_clear <= 1'b1;
        @(posedge clock);
        status_clear <= 1'b0;
        hit(1'b0, 1'b1, 2'b01);
        seq(3'h2, 12'h2C4, 12'h2C4);
        @(posedge clock);
        read_location <= 1'b1;
        @(posedge clock);
        read_location <= 1'b0;
        #1 chk({a_operand_valid, a_operand_bus}, 17'h102C5);
        @(posedge clock);
        {console_load, console_word} <= {1'b1, 48'hC0FFEE123456};
        @(posedge clock);
        console_load <= 1'b0;
        #1 chk(microcommand_register_reg, 48'hC0FFEE123456);
        seq(3'h2, 12'h0F0, 12'h0F0);
        @(posedge clock);
        {modify_enable, modify_mask, modify_value} <= {1'b1, 48'hFF, 48'h5A};
        @(posedge clock);
        modify_enable <= 1'b0;
        #1 chk(microcommand_register_reg, 48'h0F1F0E0F1F5A);
    endtask
    task t_stores;
        @(posedge clock);
        {wcs_access, wcs_write, wcs_select, wcs_addr} <= {3'b111, 12'h0F3};
        wcs_wdata <= 48'hA5A5A5A5A5A5;
        @(posedge clock);
        {wcs_access, wcs_write} <= 2'b00;
        seq(3'h2, 12'h0F3, 12'h0F3);
        wcs_access <= 1'b1;
        @(posedge clock);
        {wcs_select, wcs_access} <= 2'b00;
        #1 chk(microcommand_register_reg, 48'hA5A5A5A5A5A5);
        chk(wcs_rdata_reg, 48'hA5A5A5A5A5A5);
        chk(wcs_rvalid_reg, 1'b1);
        {patch_write, patch_enable, patch_block0, patch_waddr} <= {3'b101, 7'h0A, 5'h04};
        patch_wdata <= 48'h0123456789AB;
        @(posedge clock);
        patch_write <= 1'b0;
        seq(3'h2, 12'h144, 12'h144);
        @(posedge clock);
        patch_enable <= 2'b00;
        #1 chk(microcommand_register_reg, 48'h0123456789AB);
    endtask
    initial begin
        {rstn, system_error, power_up, status_clear, wcs_select, wcs_access, wcs_write} = '0;
        {modify_enable, console_load, hold, patch_write, branch_cond, page_select} = '0;
        {page_toggle, stack_up, stack_down, repeat_step, read_location, patch_enable} = '0;
        {stack_op, loop_op, next_source, patch_waddr, patch_block0, intr_vector} = '0;
        {loop_value, emul_vector, wcs_addr, result_bus, modify_mask, modify_value} = '0;
        {console_word, patch_wdata, wcs_wdata, errors, n_tests} = '0;
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        t_count;
        t_branch;
        t_stack;
        t_loop;
        t_misc;
        t_stores;
        end_sim;
    end
    initial begin
        repeat (2000) @(posedge clock);
        errors++;
        end_sim;
    end
endmodule // test_microprogram_sequencer
`default_nettype wire
